// ===== logic/tap_pkg.sv
package tap_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int IR_WIDTH      = 3;
    localparam int NUM_PADS      = 8;
    localparam int CELLS_PER_PAD = 3;
    localparam int CHAIN_LEN     = NUM_PADS * CELLS_PER_PAD;
    localparam int SYNC_STAGES   = 3;
    // bit positions of the test port pins inside their synchroniser
    localparam int PORT_WIDTH    = 3;
    localparam int PORT_TCK      = 2;
    localparam int PORT_TMS      = 1;
    localparam int PORT_TDI      = 0;

    // cell positions inside one pad group, tdi side first
    localparam int CELL_IN  = 0;
    localparam int CELL_OE  = 1;
    localparam int CELL_OUT = 2;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_WIDTH-1:0] INSTR_EXTEST         = 3'h0;
    localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE         = 3'h1;
    localparam logic [IR_WIDTH-1:0] INSTR_SPLIT_EXTEST   = 3'h2;
    localparam logic [IR_WIDTH-1:0] INSTR_SPLIT_SAMPLE   = 3'h3;
    localparam logic [IR_WIDTH-1:0] INSTR_RESERVED       = 3'h4;
    localparam logic [IR_WIDTH-1:0] INSTR_TRISTATE       = 3'h5;
    localparam logic [IR_WIDTH-1:0] INSTR_CONTINUITY     = 3'h6;
    localparam logic [IR_WIDTH-1:0] INSTR_BYPASS         = 3'h7;
    // fixed pattern loaded on capture, low two bits as usual for a tap
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE     = 3'h1;
    localparam logic                BYPASS_CAPTURE_VALUE = 1'h0;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR     = 4'h0,
        ST_RTI     = 4'h1,
        ST_SEL_DR  = 4'h2,
        ST_CAP_DR  = 4'h3,
        ST_SH_DR   = 4'h4,
        ST_EX1_DR  = 4'h5,
        ST_PA_DR   = 4'h6,
        ST_EX2_DR  = 4'h7,
        ST_UPD_DR  = 4'h8,
        ST_SEL_IR  = 4'h9,
        ST_CAP_IR  = 4'hA,
        ST_SH_IR   = 4'hB,
        ST_EX1_IR  = 4'hC,
        ST_PA_IR   = 4'hD,
        ST_EX2_IR  = 4'hE,
        ST_UPD_IR  = 4'hF
    } tap_state_e;

endpackage : tap_pkg

// ===== logic/sync3.sv
`timescale 1ns/1ns
`default_nettype none

// three-stage synchroniser; the first stage feeds only the second
module sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // asynchronous level in
    input  wire logic [WIDTH-1:0] async_in,
    // second and third stages
    output logic      [WIDTH-1:0] stage2,
    output logic      [WIDTH-1:0] stage3
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign stage2 = stage2_reg;
    assign stage3 = stage3_reg;

endmodule : sync3

`default_nettype wire

// ===== logic/bscan_pad_cell.sv
`timescale 1ns/1ns
`default_nettype none

// one pad: input cell, output-enable cell, output cell
module bscan_pad_cell
    import tap_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // strobes from the controller
    input  wire logic capture,
    input  wire logic shift,
    input  wire logic update,
    // serial chain
    input  wire logic scan_in,
    output logic      scan_out,
    // pad modes
    input  wire logic drive_ext,
    input  wire logic hiz_all,
    input  wire logic zero_all,
    // core side
    input  wire logic core_out,
    input  wire logic core_oe,
    output logic      core_in,
    // pad side
    input  wire logic pad_in_sync,
    output logic      pad_out,
    output logic      pad_oe
);
    logic [CELLS_PER_PAD-1:0] cell_reg;
    logic [CELLS_PER_PAD-1:0] cell_next;
    logic                     upd_out_reg;
    logic                     upd_oe_reg;
    logic [CELLS_PER_PAD-1:0] captured;

    // enable cell makes the direction control observable
    assign captured[CELL_IN]  = pad_in_sync;
    assign captured[CELL_OE]  = core_oe;
    assign captured[CELL_OUT] = core_out;
    assign cell_next = capture ? captured
                     : shift   ? {cell_reg[CELLS_PER_PAD-2:0], scan_in}
                     : cell_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_reg <= '0;
        end else begin
            cell_reg <= cell_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_out_reg <= 1'h0;
            upd_oe_reg  <= 1'h0;
        end else if (update) begin
            upd_out_reg <= cell_reg[CELL_OUT];
            upd_oe_reg  <= cell_reg[CELL_OE];
        end
    end

    assign scan_out = cell_reg[CELLS_PER_PAD-1];
    assign core_in  = pad_in_sync;
    assign pad_oe   = hiz_all   ? 1'h0
                    : zero_all  ? 1'h1
                    : drive_ext ? upd_oe_reg : core_oe;
    assign pad_out  = zero_all  ? 1'h0
                    : drive_ext ? upd_out_reg : core_out;

endmodule : bscan_pad_cell

`default_nettype wire

// ===== logic/tap_controller.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - serial test port of four signals: test clock, data in, data out, mode select
// - full sixteen-state tap controller stepped by mode select at test clock rise
// - controller issues capture, shift and update strobes; the bypass register takes only capture and shift
// - three-bit serially loaded instruction register selects the test operation
// - code 000: external test, chain data drives the output pins
// - code 001: sample/preload, pin values captured and shifted out
// - code 010: split-bus external test, chain data drives outputs
// - code 011: split-bus sample/preload, pins captured and shifted out
// - code 101: all port pads go high impedance
// - code 111: bypass, loaded automatically at power-up
// - bypass register is one stage between data in and data out
// - bypass path selected for bypass code and after power-up
// - chain holds one cell group per pad, data in to data out
// - chain captures each bidirectional pad's output enable
module tap_controller
    import tap_pkg::*;
(
    // clock and power-up reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // test port
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    output logic                     tdo,
    output logic                     tdo_oe,
    // core side of the pads
    input  wire logic [NUM_PADS-1:0] core_out,
    input  wire logic [NUM_PADS-1:0] core_oe,
    output logic      [NUM_PADS-1:0] core_in,
    // pads
    input  wire logic [NUM_PADS-1:0] pad_in,
    output logic      [NUM_PADS-1:0] pad_out,
    output logic      [NUM_PADS-1:0] pad_oe,
    // mode flag for the split host bus
    output logic                     split_bus_select
);
    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    logic [PORT_WIDTH-1:0] port_s2;
    logic [PORT_WIDTH-1:0] port_s3;
    logic [PORT_WIDTH-1:0] port_lvl_reg;
    logic [NUM_PADS-1:0]   pad_s2;
    logic [NUM_PADS-1:0]   pad_s3;
    logic [NUM_PADS-1:0]   pad_lvl_reg;
    logic                  tck_agree;
    logic                  tck_rise;
    logic                  tck_fall;
    logic                  tms_s;
    logic                  tdi_s;

    sync3 #(.WIDTH(PORT_WIDTH)) u_port_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({tck, tms, tdi}),
        .stage2   (port_s2),
        .stage3   (port_s3)
    );

    sync3 #(.WIDTH(NUM_PADS)) u_pad_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pad_in),
        .stage2   (pad_s2),
        .stage3   (pad_s3)
    );

    // a level or edge counts only once stages two and three agree
    assign tck_agree = (port_s2[PORT_TCK] == port_s3[PORT_TCK]);
    assign tck_rise  = tck_agree & port_s3[PORT_TCK] & ~port_lvl_reg[PORT_TCK];
    assign tck_fall  = tck_agree & ~port_s3[PORT_TCK] & port_lvl_reg[PORT_TCK];
    assign tms_s     = port_lvl_reg[PORT_TMS];
    assign tdi_s     = port_lvl_reg[PORT_TDI];

    // tck idles low when unused, so reset matches the parked level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_lvl_reg <= '0;
            pad_lvl_reg  <= '0;
        end else begin
            port_lvl_reg <= (port_s2 & port_s3) | ((port_s2 ^ port_s3) & port_lvl_reg);
            pad_lvl_reg  <= (pad_s2 & pad_s3) | ((pad_s2 ^ pad_s3) & pad_lvl_reg);
        end
    end

    // ------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------
    tap_state_e state_reg;
    tap_state_e state_next;
    tap_state_e state_step;

    always_comb begin
        case (state_reg)
            ST_TLR:    state_step = tms_s ? ST_TLR    : ST_RTI;
            ST_RTI:    state_step = tms_s ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_step = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_step = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_step = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_step = tms_s ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  state_step = tms_s ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_step = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_step = tms_s ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_step = tms_s ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: state_step = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_step = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_step = tms_s ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  state_step = tms_s ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_step = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_step = tms_s ? ST_SEL_DR : ST_RTI;
            default:   state_step = ST_TLR;
        endcase
    end

    assign state_next = tck_rise ? state_step : state_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_TLR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    logic in_shift_ir;
    logic in_shift_dr;
    logic ir_capture;
    logic ir_shift;
    logic ir_update;
    logic dr_capture;
    logic dr_shift;
    logic dr_update;

    assign in_shift_ir = (state_reg == ST_SH_IR);
    assign in_shift_dr = (state_reg == ST_SH_DR);
    assign ir_capture  = tck_rise & (state_reg == ST_CAP_IR);
    assign ir_shift    = tck_rise & in_shift_ir;
    assign ir_update   = tck_fall & (state_reg == ST_UPD_IR);
    assign dr_capture  = tck_rise & (state_reg == ST_CAP_DR);
    assign dr_shift    = tck_rise & in_shift_dr;
    assign dr_update   = tck_fall & (state_reg == ST_UPD_DR);

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [IR_WIDTH-1:0] ir_shift_reg;
    logic [IR_WIDTH-1:0] ir_shift_next;
    logic [IR_WIDTH-1:0] instr_reg;
    logic [IR_WIDTH-1:0] instr_next;

    // lsb leaves first, new bits enter at the msb
    assign ir_shift_next = ir_capture ? IR_CAPTURE_VALUE
                         : ir_shift   ? {tdi_s, ir_shift_reg[IR_WIDTH-1:1]}
                         : ir_shift_reg;
    // the reset state forces bypass, as power-up does
    assign instr_next    = (state_reg == ST_TLR) ? INSTR_BYPASS
                         : ir_update             ? ir_shift_reg
                         : instr_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_reg <= IR_CAPTURE_VALUE;
        end else begin
            ir_shift_reg <= ir_shift_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg <= INSTR_BYPASS;
        end else begin
            instr_reg <= instr_next;
        end
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    logic sel_extest;
    logic sel_sample;
    logic sel_bscan;
    logic sel_bypass;
    logic hiz_all;
    logic zero_all;

    assign sel_extest = (instr_reg == INSTR_EXTEST)
                      | (instr_reg == INSTR_SPLIT_EXTEST);
    assign sel_sample = (instr_reg == INSTR_SAMPLE)
                      | (instr_reg == INSTR_SPLIT_SAMPLE);
    assign sel_bscan  = sel_extest | sel_sample;
    // reserved, tristate and continuity all shift through bypass
    assign sel_bypass = ~sel_bscan;
    assign hiz_all    = (instr_reg == INSTR_TRISTATE);
    assign zero_all   = (instr_reg == INSTR_CONTINUITY);
    assign split_bus_select = (instr_reg == INSTR_SPLIT_EXTEST)
                            | (instr_reg == INSTR_SPLIT_SAMPLE);

    // ------------------------------------------------------------
    // bypass register
    // ------------------------------------------------------------
    logic bypass_reg;
    logic bypass_next;

    assign bypass_next = (dr_capture & sel_bypass) ? BYPASS_CAPTURE_VALUE
                       : (dr_shift & sel_bypass)   ? tdi_s
                       : bypass_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_reg <= BYPASS_CAPTURE_VALUE;
        end else begin
            bypass_reg <= bypass_next;
        end
    end

    // ------------------------------------------------------------
    // boundary-scan chain
    // ------------------------------------------------------------
    logic [NUM_PADS:0] chain_link;

    assign chain_link[0] = tdi_s;

    generate
        for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
            bscan_pad_cell u_cell (
                .clk         (clk),
                .rst_n       (rst_n),
                .capture     (dr_capture & sel_bscan),
                .shift       (dr_shift & sel_bscan),
                .update      (dr_update & sel_bscan),
                .scan_in     (chain_link[i]),
                .scan_out    (chain_link[i+1]),
                .drive_ext   (sel_extest),
                .hiz_all     (hiz_all),
                .zero_all    (zero_all),
                .core_out    (core_out[i]),
                .core_oe     (core_oe[i]),
                .core_in     (core_in[i]),
                .pad_in_sync (pad_lvl_reg[i]),
                .pad_out     (pad_out[i]),
                .pad_oe      (pad_oe[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // test data out
    // ------------------------------------------------------------
    logic tdo_reg;
    logic tdo_next;
    logic tdo_oe_reg;
    logic tdo_oe_next;

    assign tdo_next    = in_shift_ir ? ir_shift_reg[0]
                       : sel_bypass  ? bypass_reg
                       : chain_link[NUM_PADS];
    // launched on the fall so the far end samples it on the next rise
    assign tdo_oe_next = in_shift_ir | in_shift_dr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_reg    <= 1'h0;
            tdo_oe_reg <= 1'h0;
        end else if (tck_fall) begin
            tdo_reg    <= tdo_next;
            tdo_oe_reg <= tdo_oe_next;
        end
    end

    assign tdo    = tdo_reg;
    assign tdo_oe = tdo_oe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_tlr_bypass_load:
    assert property (state_reg == ST_TLR |=> instr_reg == INSTR_BYPASS)
        else $error("reset state did not load bypass");

    a_select_ir_exit:
    assert property (tck_rise && tms_s && state_reg == ST_SEL_IR |=> state_reg == ST_TLR)
        else $error("select-ir with tms high did not reach reset state");

    a_state_holds:
    assert property (!tck_rise |=> $stable(state_reg))
        else $error("state moved without a test clock rise");

    a_ir_capture_val:
    assert property (ir_capture |=> ir_shift_reg == IR_CAPTURE_VALUE)
        else $error("instruction capture value wrong");

    a_ir_update_load:
    assert property (ir_update |=> instr_reg == $past(ir_shift_reg))
        else $error("instruction not loaded on update");

    a_bypass_shift:
    assert property (dr_shift && sel_bypass |=> bypass_reg == $past(tdi_s))
        else $error("bypass stage did not take data in");

    a_tdo_fall_only:
    assert property ($changed(tdo_reg) || $changed(tdo_oe_reg) |-> $past(tck_fall))
        else $error("data out moved off a falling edge");

    a_tdo_hiz_idle:
    assert property (tck_fall && !in_shift_ir && !in_shift_dr |=> !tdo_oe)
        else $error("data out driven outside shift");

    a_tristate_pads:
    assert property (instr_reg == INSTR_TRISTATE |-> pad_oe == '0)
        else $error("pads not released in tristate mode");

    a_continuity_pads:
    assert property (instr_reg == INSTR_CONTINUITY |-> pad_oe == '1 && pad_out == '0)
        else $error("pads not driven low in continuity mode");

    a_reserved_bypass:
    assert property (instr_reg == INSTR_RESERVED |-> sel_bypass && !hiz_all && !zero_all)
        else $error("reserved code not treated as bypass");

endmodule : tap_controller

`default_nettype wire

// ===== bench/jtag_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------
// board scan host: tck stands low between scans
// ----------
module jtag_host_model (
    // test port
    output var logic        tck,
    output var logic        tms,
    output var logic        tdi,
    input  wire logic       tdo,
    input  wire logic       tdo_oe,
    // scan results
    output var logic [31:0] rx_word,
    output var logic        rx_oe_ok,
    output var logic        rx_strobe
);
    logic tdo_line;
    logic oe_seen;
    logic ok;

    initial begin
        tck       = 1'b0;
        tms       = 1'b1;
        tdi       = 1'b1;
        rx_word   = 32'h0;
        rx_oe_ok  = 1'b0;
        rx_strobe = 1'b0;
        tdo_line  = 1'b0;
        oe_seen   = 1'b0;
        ok        = 1'b1;
    end

    // high 64 ns, low 96 ns: tdo is read late in the low phase
    task automatic step(input logic m, input logic d);
        #16;
        tms = m;
        tdi = d;
        #76;
        oe_seen  = tdo_oe;
        // released pin shows no stale value
        tdo_line = tdo_oe ? tdo : ~tdo_line;
        #4;
        tck = 1'b1;
        #64;
        tck = 1'b0;
    endtask : step

    // from run-test-idle back to run-test-idle
    task automatic scan(input logic is_instr, input int n, input logic [31:0] din);
        logic [31:0] dout;
        dout = 32'h0;
        step(1'b1, 1'b1);
        if (is_instr) step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        ok = !oe_seen;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = tdo_line;
            ok &= oe_seen;
        end
        step(1'b1, 1'b1);
        ok &= !oe_seen;
        step(1'b0, 1'b1);
        rx_word   = dout;
        rx_oe_ok  = ok;
        rx_strobe = 1'b1;
        #1;
        rx_strobe = 1'b0;
    endtask : scan
endmodule : jtag_host_model

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import tap_pkg::*;
;
    typedef struct {
        string       name;
        logic [31:0] val;
        logic [31:0] mask;
    } note_s;

    logic                clk, rst_n, tck, tms, tdi, tdo, tdo_oe, split_bus_select;
    logic [NUM_PADS-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
    logic [31:0]         rx_word;
    logic                rx_oe_ok, rx_strobe;
    note_s               notes[$];
    int                  err_count = 0;
    int                  samples_checked = 0;
    int                  cycles = 0;
    event                pad_look;

    tap_controller u_tap_controller (
        .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
        .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .split_bus_select(split_bus_select)
    );

    jtag_host_model u_jtag_host_model (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .rx_word(rx_word), .rx_oe_ok(rx_oe_ok), .rx_strobe(rx_strobe)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run is some 2550 cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    // ----------
    // checking
    // ----------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic take(input logic [31:0] seen);
        note_s n;
        if (notes.size() == 0) begin
            err_count = err_count + 1;
            $display("unexpected result: expected none seen %h", seen);
            return;
        end
        n = notes.pop_front();
        check(n.name, seen & n.mask, n.val);
    endtask : take

    // bit 31 of a scan result is the enable-window verdict
    always @(posedge rx_strobe) take({rx_oe_ok, rx_word[30:0]});
    always @(pad_look) take({7'h0, split_bus_select, core_in, pad_oe, pad_out});

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // ----------
    // expectations
    // ----------
    function automatic logic [31:0] cap_exp();
        logic [31:0] e;
        e = 32'h8000_0000;
        for (int p = 0; p < NUM_PADS; p++) begin
            e[CHAIN_LEN-1-(p*CELLS_PER_PAD+CELL_IN)]  = pad_in[p];
            e[CHAIN_LEN-1-(p*CELLS_PER_PAD+CELL_OE)]  = core_oe[p];
            e[CHAIN_LEN-1-(p*CELLS_PER_PAD+CELL_OUT)] = core_out[p];
        end
        return e;
    endfunction : cap_exp

    function automatic logic [31:0] pads_exp(input logic [2:0] c, input logic [31:0] din);
        logic [NUM_PADS-1:0] po, pe;
        po = core_out;
        pe = core_oe;
        for (int p = 0; p < NUM_PADS; p++) begin
            if (c == INSTR_EXTEST || c == INSTR_SPLIT_EXTEST) begin
                po[p] = din[CHAIN_LEN-1-(p*CELLS_PER_PAD+CELL_OUT)];
                pe[p] = din[CHAIN_LEN-1-(p*CELLS_PER_PAD+CELL_OE)];
            end
        end
        if (c == INSTR_TRISTATE) pe = '0;
        if (c == INSTR_CONTINUITY) begin
            po = '0;
            pe = '1;
        end
        return {7'h0, c[2:1] == 2'b01, pad_in, pe, po};
    endfunction : pads_exp

    // ----------
    // stimulus
    // ----------
    task automatic expect_val(input string what, input logic [31:0] v, input logic [31:0] m);
        notes.push_back('{what, v & m, m});
    endtask : expect_val

    task automatic shuffle_pins();
        @(negedge clk);
        core_out = NUM_PADS'($urandom());
        core_oe  = NUM_PADS'($urandom());
        pad_in   = NUM_PADS'($urandom());
    endtask : shuffle_pins

    task automatic instr_load(input logic [2:0] c);
        expect_val("instr capture", {1'b1, 28'h0, IR_CAPTURE_VALUE}, 32'h8000_0007);
        u_jtag_host_model.scan(1'b1, IR_WIDTH, {29'h0, c});
    endtask : instr_load

    task automatic dr_scan(input logic [2:0] c, input logic [31:0] din);
        if (c[2]) begin
            expect_val("bypass", {1'b1, 23'h0, din[6:0], BYPASS_CAPTURE_VALUE},
                       32'h8000_00FF);
            u_jtag_host_model.scan(1'b0, 8, din);
        end else begin
            expect_val("chain", cap_exp(), 32'h80FF_FFFF);
            u_jtag_host_model.scan(1'b0, CHAIN_LEN, din);
        end
        repeat (6) @(negedge clk);
        expect_val("pads", pads_exp(c, din), 32'h01FF_FFFF);
        -> pad_look;
    endtask : dr_scan

    initial begin
        logic [2:0] code;
        rst_n    = 1'b0;
        core_out = '0;
        core_oe  = '0;
        pad_in   = '0;
        void'($urandom(32'h137E12F6));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        shuffle_pins();
        u_jtag_host_model.step(1'b0, 1'b1);
        dr_scan(INSTR_BYPASS, $urandom());
        for (int i = 0; i < 8; i++) begin
            code = 3'(i);
            shuffle_pins();
            instr_load(code);
            dr_scan(code, $urandom());
        end
        // five tms highs reach reset and restore bypass
        shuffle_pins();
        instr_load(INSTR_EXTEST);
        repeat (5) u_jtag_host_model.step(1'b1, 1'b1);
        u_jtag_host_model.step(1'b0, 1'b1);
        dr_scan(INSTR_BYPASS, $urandom());
        // power-up reset in mid-run with continuity loaded
        instr_load(INSTR_CONTINUITY);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        u_jtag_host_model.step(1'b0, 1'b1);
        dr_scan(INSTR_BYPASS, $urandom());
        repeat (4) @(negedge clk);
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
